// File: verilog/rtc_time_base_regs.vh
// Constants of the real-time clock time base: rates, stage widths,
// clock-out selections and restart timing.
// Assumes inclusion by its bare name from the time-base modules.
`ifndef RTC_TIME_BASE_REGS_VH
`define RTC_TIME_BASE_REGS_VH

// Oscillator rate and system clock rate
`define OSC_HZ              32768
`define CLK_HZ              10000000

// Prescaler split: F0..F1, F2..F8, F9..F14
`define LOW_STAGES          2
`define MID_STAGES          7
`define TOP_STAGES          6

// Earliest first increment after halt release, in microseconds
`define FIRST_TICK_MIN_US   507813
// Latest first increment after halt release, in microseconds
`define FIRST_TICK_MAX_US   507935

// Clock-out frequency selections
`define CLKSEL_32768HZ      2'h0
`define CLKSEL_1024HZ       2'h1
`define CLKSEL_32HZ         2'h2
`define CLKSEL_1HZ          2'h3

// Reset values
`define SECONDS_RESET       32'h0000_0000
`define CLKSEL_RESET        2'h0

`endif

// File: verilog/prescaler_top_divider.v
// Six-stage binary divider forming the upper prescaler (64 Hz to 1 Hz).
// Assumes advance is a one-cycle pulse on clk, one per input tap edge.
`include "rtc_time_base_regs.vh"

module prescaler_top_divider (
  // Clock and reset
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire                     ce,
  // Control
  input  wire                     clear,
  input  wire                     advance,
  // Result
  output reg  [`TOP_STAGES-1:0]   count_reg,
  output reg                      top_rise_reg
);

  wire [`TOP_STAGES-1:0] count_next = count_reg + {{(`TOP_STAGES-1){1'b0}}, 1'b1};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg    <= {`TOP_STAGES{1'b0}};
      top_rise_reg <= 1'b0;
    end else if (ce) begin
      top_rise_reg <= 1'b0;
      if (clear) begin
        count_reg <= {`TOP_STAGES{1'b0}};
      end else if (advance) begin
        count_reg    <= count_next;
        // Top stage going 0 to 1 is the 1 Hz tick
        top_rise_reg <= ~count_reg[`TOP_STAGES-1] &
                        count_next[`TOP_STAGES-1];
      end
    end
  end

endmodule // prescaler_top_divider

// File: verilog/two_wire_bit_monitor.v
// Bit-level watcher of the two-wire serial bus: start, stop, data bits,
// and an open-drain data driver that only changes while the clock is low.
// Assumes scl_in and sda_in are already synchronous to clk.

module two_wire_bit_monitor (
  // Clock and reset
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  // Bus lines
  input  wire scl_in,
  input  wire sda_in,
  output reg  sda_out_reg,
  output reg  sda_oe_reg,
  // Transmit request
  input  wire tx_enable,
  input  wire tx_bit,
  // Events
  output reg  start_reg,
  output reg  stop_reg,
  output reg  bit_valid_reg,
  output reg  bit_value_reg,
  output reg  busy_reg
);

  reg scl_prev_reg;
  reg sda_prev_reg;

  wire scl_high_both = scl_in & scl_prev_reg;
  wire start_seen    = scl_high_both & sda_prev_reg & ~sda_in;
  wire stop_seen     = scl_high_both & ~sda_prev_reg & sda_in;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_reg  <= 1'b1;
      sda_prev_reg  <= 1'b1;
      sda_out_reg   <= 1'b0;
      sda_oe_reg    <= 1'b0;
      start_reg     <= 1'b0;
      stop_reg      <= 1'b0;
      bit_valid_reg <= 1'b0;
      bit_value_reg <= 1'b0;
      busy_reg      <= 1'b0;
    end else if (ce) begin
      scl_prev_reg  <= scl_in;
      sda_prev_reg  <= sda_in;
      start_reg     <= start_seen;
      stop_reg      <= stop_seen;
      // One bit per clock pulse, taken at the rising clock edge
      bit_valid_reg <= scl_in & ~scl_prev_reg;
      if (scl_in & ~scl_prev_reg) begin
        bit_value_reg <= sda_in;
      end
      // Idle means both lines released since the last stop
      if (start_seen) begin
        busy_reg <= 1'b1;
      end else if (stop_seen) begin
        busy_reg <= 1'b0;
      end
      // Data driver moves only while the clock is low
      if (!scl_in) begin
        sda_oe_reg <= tx_enable & ~tx_bit;
      end
    end
  end

endmodule // two_wire_bit_monitor

// File: verilog/rtc_time_base.v
// Prescaler, halt, external-clock test mode and clock-out of an RTC.
// Assumes all inputs synchronous to clk; osc_in is the 32.768 kHz level.
`include "rtc_time_base_regs.vh"

module rtc_time_base (
  // Clock, reset and enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // Oscillator
  input  wire        osc_in,
  // Control bits
  input  wire        ext_clock_test_select,
  input  wire        halt,
  input  wire        clock_out_pin_enable,
  input  wire [1:0]  clock_out_pin_freq_sel,
  // Clock-out pin, open drain
  input  wire        clock_out_pin_in,
  output wire        clock_out_pin_out,
  output wire        clock_out_pin_oe,
  // Time counter
  input  wire        time_write,
  input  wire [31:0] time_write_value,
  output wire [31:0] seconds_count,
  output wire        second_tick,
  // Status
  output wire        external_clock_test_mode,
  output wire        prescaler_stage_zero,
  output wire        prescaler_top_stage,
  // Two-wire bus
  input  wire        scl_in,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe,
  input  wire        tx_enable,
  input  wire        tx_bit,
  output wire        bus_start,
  output wire        bus_stop,
  output wire        bit_valid,
  output wire        bit_value,
  output wire        bus_busy
);

  // Oscillator edges from prescaler reset to first top-stage rise
  localparam [63:0] FULL_EDGES = 64'd16384;
  // Earliest first tick in oscillator edges, rounded up
  localparam [63:0] MIN_EDGES  =
    (64'd`FIRST_TICK_MIN_US * 64'd`OSC_HZ + 64'd999999) / 64'd1000000;
  // Extra hold after release so that F0/F1 in 0..3 lands in the window
  localparam [63:0] RESTART_64 = MIN_EDGES - FULL_EDGES +
    64'd`LOW_STAGES + 64'd1;
  localparam [8:0]  RESTART_EDGES = RESTART_64[8:0];

  reg                     test_mode_reg;
  reg                     halt_reg;
  reg                     osc_prev_reg;
  reg                     ext_prev_reg;
  reg [`LOW_STAGES-1:0]   low_reg;
  reg [`MID_STAGES-1:0]   mid_reg;
  reg [8:0]               restart_reg;
  reg [31:0]              seconds_reg;
  reg                     tick_reg;
  reg                     pin_oe_reg;
  reg                     pin_out_reg;

  wire [`TOP_STAGES-1:0]  top_count;
  wire                    top_rise;

  wire osc_rise = osc_in & ~osc_prev_reg;
  wire ext_rise = test_mode_reg & clock_out_pin_in & ~ext_prev_reg;
  wire low_wrap = osc_rise & (&low_reg);
  wire mid_wrap = low_wrap & (&mid_reg);
  // Restart hold only applies to the internal tap
  wire hold_upper = halt_reg |
                    (~test_mode_reg & (restart_reg != 9'h000));

  // 64 Hz tap: internal carry or the pin in test mode
  wire tap_advance = test_mode_reg ? ext_rise : mid_wrap;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_mode_reg <= 1'b0;
      halt_reg      <= 1'b0;
      osc_prev_reg  <= 1'b0;
      ext_prev_reg  <= 1'b0;
    end else if (ce) begin
      test_mode_reg <= ext_clock_test_select;
      halt_reg      <= halt;
      osc_prev_reg  <= osc_in;
      ext_prev_reg  <= clock_out_pin_in;
    end
  end

  // F0 and F1: run from the oscillator, halt never touches them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_reg <= {`LOW_STAGES{1'b0}};
    end else if (ce && osc_rise) begin
      low_reg <= low_reg + {{(`LOW_STAGES-1){1'b0}}, 1'b1};
    end
  end

  // F2..F8 held clear while halted or in the restart hold
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mid_reg <= {`MID_STAGES{1'b0}};
    end else if (ce) begin
      if (hold_upper) begin
        mid_reg <= {`MID_STAGES{1'b0}};
      end else if (low_wrap) begin
        mid_reg <= mid_reg + {{(`MID_STAGES-1){1'b0}}, 1'b1};
      end
    end
  end

  // Restart hold: loaded while halted, counts oscillator edges after
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_reg <= 9'h000;
    end else if (ce) begin
      if (halt_reg) begin
        restart_reg <= RESTART_EDGES;
      end else if (osc_rise && restart_reg != 9'h000) begin
        restart_reg <= restart_reg - 9'h001;
      end
    end
  end

  // Top six stages; in test mode 32 pin edges reach F14, 64 per second
  prescaler_top_divider u_top (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .clear        (hold_upper),
    .advance      (tap_advance),
    .count_reg    (top_count),
    .top_rise_reg (top_rise)
  );

  // Time counter: writes always accepted, ticks only when not halted
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seconds_reg <= `SECONDS_RESET;
      tick_reg    <= 1'b0;
    end else if (ce) begin
      tick_reg <= top_rise & ~time_write;
      if (time_write) begin
        seconds_reg <= time_write_value;
      end else if (top_rise) begin
        seconds_reg <= seconds_reg + 32'h0000_0001;
      end
    end
  end

  // Clock-out level; low drives the pin, high releases it
  reg clock_out_pin_level;
  always @* begin
    case (clock_out_pin_freq_sel)
      `CLKSEL_32768HZ: clock_out_pin_level = osc_prev_reg;
      `CLKSEL_1024HZ:  clock_out_pin_level = mid_reg[2];
      `CLKSEL_32HZ:    clock_out_pin_level = top_count[0];
      default:         clock_out_pin_level = top_count[5];
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_reg  <= 1'b0;
      pin_out_reg <= 1'b0;
    end else if (ce) begin
      pin_out_reg <= 1'b0;
      // Pin stays released in test mode so it can act as an input
      pin_oe_reg  <= clock_out_pin_enable & ~test_mode_reg &
                     ~clock_out_pin_level;
    end
  end

  two_wire_bit_monitor u_bus (
    .clk           (clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .scl_in        (scl_in),
    .sda_in        (sda_in),
    .sda_out_reg   (sda_out),
    .sda_oe_reg    (sda_oe),
    .tx_enable     (tx_enable),
    .tx_bit        (tx_bit),
    .start_reg     (bus_start),
    .stop_reg      (bus_stop),
    .bit_valid_reg (bit_valid),
    .bit_value_reg (bit_value),
    .busy_reg      (bus_busy)
  );

  assign clock_out_pin_out        = pin_out_reg;
  assign clock_out_pin_oe         = pin_oe_reg;
  assign seconds_count            = seconds_reg;
  assign second_tick              = tick_reg;
  assign external_clock_test_mode = test_mode_reg;
  assign prescaler_stage_zero     = low_reg[0];
  assign prescaler_top_stage      = top_count[5];

endmodule // rtc_time_base

// File: dv/rtc_time_base_assertions.sv
// Checker of rtc_time_base port behaviour: test mode, halt, ticks, bus.
// Assumes ce held high, so every clock edge is a live cycle.
module rtc_time_base_checker (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Oscillator and lowest stage
  input wire        osc_in,
  input wire        prescaler_stage_zero,
  // Control
  input wire        ext_clock_test_select,
  input wire        halt,
  input wire        clock_out_pin_enable,
  input wire [1:0]  clock_out_pin_freq_sel,
  input wire        time_write,
  input wire [31:0] time_write_value,
  // Time base
  input wire        clock_out_pin_out,
  input wire        clock_out_pin_oe,
  input wire [31:0] seconds_count,
  input wire        second_tick,
  input wire        external_clock_test_mode,
  input wire        prescaler_top_stage,
  // Two-wire bus
  input wire        scl_in,
  input wire        sda_in,
  input wire        sda_out,
  input wire        sda_oe,
  input wire        bus_start,
  input wire        bus_stop,
  input wire        bit_valid,
  input wire        bit_value,
  input wire        bus_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_MODE_FOLLOWS: assert property ($stable(ext_clock_test_select) [*3] |->
    external_clock_test_mode == ext_clock_test_select)
    else $error("test mode does not follow select");
  AST_PIN_INPUT: assert property (external_clock_test_mode [*2] |-> !clock_out_pin_oe)
    else $error("clock-out pin driven in test mode");
  AST_OPEN_DRAIN: assert property (!clock_out_pin_out && !sda_out)
    else $error("open-drain output driven high");
  AST_HALT_HOLD: assert property (halt [*4] |-> !prescaler_top_stage && !second_tick)
    else $error("prescaler runs while halted");
  AST_HALT_CLOCK_OUT_PIN: assert property ((halt && clock_out_pin_enable &&
    !ext_clock_test_select && clock_out_pin_freq_sel != 2'h0) [*5] |-> clock_out_pin_oe)
    else $error("slow clock-out runs while halted");
  AST_TICK_EDGE: assert property (second_tick |->
    $past(prescaler_top_stage) && !$past(prescaler_top_stage, 2))
    else $error("tick without top stage rise");
  AST_SEC_INC: assert property (second_tick |->
    seconds_count == $past(seconds_count) + 32'h1)
    else $error("seconds not advanced by one");
  AST_WRITE: assert property (time_write |=>
    seconds_count == $past(time_write_value) && !second_tick)
    else $error("time write not loaded");
  AST_SDA_STEADY: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data driver changed while clock high");
  AST_START: assert property (bus_start |-> $past(scl_in) && $past(scl_in, 2) &&
    $past(sda_in, 2) && !$past(sda_in) && bus_busy)
    else $error("start without data fall under high clock");
  AST_STOP: assert property (bus_stop |->
    $past(scl_in) && !$past(sda_in, 2) && $past(sda_in) && !bus_busy)
    else $error("stop without data rise under high clock");
  AST_BIT: assert property (bit_valid && bus_busy |-> $past(scl_in) &&
    !$past(scl_in, 2) && bit_value == $past(sda_in))
    else $error("bit not taken at clock rise");
  // Halt never stops the lowest stage, so this also holds while halted
  AST_F0_TOGGLE: assert property (osc_in && !$past(osc_in) |=>
    prescaler_stage_zero != $past(prescaler_stage_zero))
    else $error("lowest stage did not follow oscillator edge");
endmodule // rtc_time_base_checker

// File: dv/two_wire_master_model.sv
// Two-wire bus master: start, data bits and stop on open-drain lines.
// Assumes the bench turns the pull-down requests into line levels.
module two_wire_master_model (
  // Clock
  input  wire  clk,
  // Pull-down requests
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  initial scl_low = 1'b0;
  initial sda_low = 1'b0;
  task automatic drive(input logic c, input logic d, input int k);
    scl_low <= c;
    sda_low <= d;
    repeat (k) @(posedge clk);
  endtask
  // Lines released first, so a transfer begins on an idle bus
  task automatic start();
    drive(1'b0, 1'b0, 4);
    drive(1'b0, 1'b1, 4);
    drive(1'b1, 1'b1, 4);
  endtask
  // Data moves only while the clock is low; k sets the speed
  task automatic put_bit(input logic b, input int k);
    drive(1'b1, ~b, k);
    drive(1'b0, ~b, k);
    drive(1'b1, ~b, k);
  endtask
  task automatic stop();
    drive(1'b1, 1'b1, 4);
    drive(1'b0, 1'b1, 4);
    drive(1'b0, 1'b0, 4);
  endtask
endmodule // two_wire_master_model

// File: dv/rtc_time_base_test.sv
// Bench of rtc_time_base: bus bits, test-mode ticks, halt and restart.
// Assumes the master model and the checker bound below.
`include "rtc_time_base_regs.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

bind rtc_time_base rtc_time_base_checker u_chk (.*);

module rtc_time_base_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LO = 64'(`FIRST_TICK_MIN_US) * 32768 / 1000000;
  localparam int HI = 64'(`FIRST_TICK_MAX_US) * 32768 / 1000000;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, osc_in = 1'b0;
  logic        ext_clock_test_select = 1'b0, halt = 1'b0, pin_drive = 1'b1;
  logic        clock_out_pin_enable = 1'b1, time_write = 1'b0, tx_enable = 1'b0;
  logic        tx_bit = 1'b0, clock_out_pin_in, clock_out_pin_out, eb;
  logic        clock_out_pin_oe, second_tick, external_clock_test_mode;
  logic        prescaler_stage_zero, prescaler_top_stage, scl_in, sda_in;
  logic        sda_out, sda_oe, bus_start, bus_stop, bit_valid, bit_value;
  logic        bus_busy, m_scl_low, m_sda_low;
  logic [1:0]  clock_out_pin_freq_sel = 2'h0;
  logic [31:0] time_write_value = 32'h0, seconds_count, sec_exp, es;
  logic [7:0]  byte_v;
  logic        exp_bits[$];
  logic [31:0] exp_secs[$];
  int          bad_count = 0, checks_done = 0, cycles = 0, osc_rises = 0;
  int          n, e;
  integer      seed;

  rtc_time_base u_dut (.*);
  two_wire_master_model u_master (.clk(clk), .scl_low(m_scl_low),
                                  .sda_low(m_sda_low));
  assign scl_in = ~m_scl_low;
  assign sda_in = ~(m_sda_low | sda_oe);
  assign clock_out_pin_in = clock_out_pin_oe ? 1'b0 : pin_drive;

  always #50 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Oscillator runs far above its real rate so a restart fits the run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles[0]) osc_in <= ~osc_in;
    if (cycles[0] && !osc_in) osc_rises <= osc_rises + 1;
    if (cycles == 80000) begin
      bad_count++;
      end_of_test();
    end
  end

  always @(posedge clk) if (rst_n) begin
    if (bit_valid && bus_busy && exp_bits.size() == 0) begin
      bad_count++;
      $display("mismatch bit_value expected none seen %h", bit_value);
    end else if (bit_valid && bus_busy) begin
      eb = exp_bits.pop_front();
      `CHK("bit_value", eb, bit_value)
    end
    if (second_tick && exp_secs.size() == 0) begin
      bad_count++;
      $display("mismatch seconds_count expected none seen %h", seconds_count);
    end else if (second_tick) begin
      es = exp_secs.pop_front();
      `CHK("seconds_count", es, seconds_count)
    end
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic pin_edges(input int k);
    repeat (k) begin
      pin_drive <= 1'b0;
      step(3);
      pin_drive <= 1'b1;
      step(3);
    end
  endtask

  initial begin
    seed = 32'h8125b7b6;
    step(20);
    rst_n <= 1'b1;
    step(4);
    byte_v = 8'($random(seed));
    u_master.start();
    `CHK("bus_busy", 1'b1, bus_busy)
    // Last bit: the device pulls data low over a released master bit
    for (int i = 7; i >= 0; i--) begin
      exp_bits.push_back(i == 0 ? 1'b0 : byte_v[i]);
      if (i == 0) begin
        tx_enable <= 1'b1;
        tx_bit    <= 1'b0;
      end
      u_master.put_bit(i == 0 ? 1'b1 : byte_v[i], i[0] ? 2 : 5);
    end
    `CHK("sda_oe", 1'b1, sda_oe)
    tx_enable <= 1'b0;
    exp_bits.push_back(1'b0);
    u_master.stop();
    `CHK("sda_oe", 1'b0, sda_oe)
    `CHK("bus_busy", 1'b0, bus_busy)
    ext_clock_test_select <= 1'b1;
    step(4);
    `CHK("test_mode", 1'b1, external_clock_test_mode)
    `CHK("pin_oe", 1'b0, clock_out_pin_oe)
    halt <= 1'b1;
    step(4);
    time_write_value <= $random(seed);
    time_write <= 1'b1;
    step(1);
    time_write <= 1'b0;
    sec_exp = time_write_value;
    pin_edges(70);
    `CHK("seconds_halted", sec_exp, seconds_count)
    halt <= 1'b0;
    step(4);
    pin_edges(31);
    `CHK("seconds_early", sec_exp, seconds_count)
    exp_secs.push_back(sec_exp + 32'h1);
    pin_edges(1);
    exp_secs.push_back(sec_exp + 32'h2);
    pin_edges(64);
    step(2);
    `CHK("ticks_left", 32'h0, 32'(exp_secs.size()))
    ext_clock_test_select <= 1'b0;
    clock_out_pin_freq_sel <= 2'h1 + 2'({$random(seed)} % 3);
    halt <= 1'b1;
    step(8);
    `CHK("test_mode", 1'b0, external_clock_test_mode)
    `CHK("pin_oe_halted", 1'b1, clock_out_pin_oe)
    exp_secs.push_back(sec_exp + 32'h3);
    halt <= 1'b0;
    n = osc_rises;
    for (int k = 0; k < 70000 && prescaler_top_stage !== 1'b1; k++) step(1);
    e = osc_rises - n;
    // One edge of slack above HI covers the sampling of the rise
    `CHK("first_tick_edges", 1'b1, (e >= LO && e <= HI + 1))
    step(4);
    `CHK("ticks_left", 32'h0, 32'(exp_secs.size()))
    end_of_test();
  end
endmodule // rtc_time_base_test
